// ### hdl/rspm_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module rspm_pin_mux (
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    global_reset_low,
  input  wire rspm_pkg::rspm_pad_type  pad_in,
  output var  rspm_pkg::rspm_pad_type  pad_out,
  output var  rspm_pkg::rspm_pad_type  pad_oe,
  input  wire logic [7:0]              pin_ctrl_reg_1,
  input  wire logic [7:0]              pin_ctrl_reg_2,
  input  wire logic [3:0]              status_clear,
  output logic [7:0]                   pin_status_reg,
  output var  rspm_pkg::rspm_strap_type straps,
  output logic                         reset_done,
  output logic                         autocfg_active,
  output logic                         reset_too_short,
  input  wire logic                    eep_select_low,
  input  wire logic                    eep_done,
  output logic                         eep_read_data,
  input  wire logic                    slave_read_active,
  input  wire logic                    slave_read_data,
  output logic                         slave_select_low
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic rspm_pkg::rspm_host_type host_decode(
    input logic s1,
    input logic s0
  );
    host_decode = rspm_pkg::rspm_host_type'({s1, s0});
  endfunction : host_decode

  function automatic logic cfg_drives(input logic [1:0] cfg);
    cfg_drives = (cfg == rspm_pkg::CFG_DRIVE_LOW) ||
                 (cfg == rspm_pkg::CFG_DRIVE_HIGH);
  endfunction : cfg_drives

  logic                     int_rst;
  rspm_pkg::rspm_state_type state_r;
  rspm_pkg::rspm_state_type state_nxt;
  rspm_pkg::rspm_strap_type strap_r;
  logic [1:0]               cfg [rspm_pkg::PIN_CNT];
  logic [3:0]               spare_oe_r;
  logic [3:0]               spare_out_r;
  logic [3:0]               live_r;
  logic [3:0]               latch_r;
  logic                     sel_oe_r;
  logic                     sel_out_r;
  logic                     dout_oe_r;
  logic                     dout_out_r;
  logic                     eep_data_r;
  logic                     slave_sel_r;
  logic                     done_r;
  logic                     autocfg_r;
  logic                     short_r;
  logic [rspm_pkg::RST_CNT_W-1:0] low_cnt_r;
  logic                     spi_host;

  // pin low resets all internal state except the reset low-time check, synchronously
  assign int_rst = srst || !global_reset_low;
  assign spi_host = (strap_r.host_mode == rspm_pkg::HOST_SPI_SLAVE) ||
                    (strap_r.host_mode == rspm_pkg::HOST_SPI_MASTER);

  // configuration field extraction
  assign cfg[0] = pin_ctrl_reg_1[rspm_pkg::CFG0_LSB +: rspm_pkg::CFG_W];
  assign cfg[1] = pin_ctrl_reg_1[rspm_pkg::CFG1_LSB +: rspm_pkg::CFG_W];
  assign cfg[2] = pin_ctrl_reg_2[rspm_pkg::CFG2_LSB +: rspm_pkg::CFG_W];
  assign cfg[3] = pin_ctrl_reg_2[rspm_pkg::CFG3_LSB +: rspm_pkg::CFG_W];

  //////////////////////////////////////////////////////////////////////////////
  // sequence state: reset, eeprom autoconfig, normal run
  always_comb begin
    state_nxt = state_r;
    if (int_rst) begin
      state_nxt = rspm_pkg::ST_RESET;
    end else begin
      unique case (state_r)
        rspm_pkg::ST_RESET: begin
          if (host_decode(pad_in.spi_data_out, pad_in.spi_select_low) ==
              rspm_pkg::HOST_SPI_MASTER) begin
            state_nxt = rspm_pkg::ST_AUTOCFG;
          end else begin
            state_nxt = rspm_pkg::ST_RUN;
          end
        end
        rspm_pkg::ST_AUTOCFG: begin
          if (eep_done) begin
            state_nxt = rspm_pkg::ST_RUN;
          end
        end
        rspm_pkg::ST_RUN: begin
          state_nxt = rspm_pkg::ST_RUN;
        end
        default: begin
          state_nxt = rspm_pkg::ST_RESET;
        end
      endcase
    end
  end

  // state and its flagged views
  always_ff @(posedge clk) begin
    state_r   <= state_nxt;
    done_r    <= state_nxt != rspm_pkg::ST_RESET;
    autocfg_r <= state_nxt == rspm_pkg::ST_AUTOCFG;
  end

  //////////////////////////////////////////////////////////////////////////////
  // strap capture on the release of the global reset, then held
  always_ff @(posedge clk) begin
    if (int_rst) begin
      strap_r <= rspm_pkg::STRAP_RST;
    end else if (state_r == rspm_pkg::ST_RESET) begin
      strap_r.factory          <= pad_in.spare[3];
      strap_r.host_mode        <= host_decode(pad_in.spi_data_out,
                                              pad_in.spi_select_low);
      strap_r.autoconfig_index <= pad_in.spare[2:0];
    end
  end

  // reset low-time check; flag survives pin reset, cleared by srst
  always_ff @(posedge clk) begin
    if (srst) begin
      low_cnt_r <= '0;
      short_r   <= 1'b0;
    end else if (!global_reset_low) begin
      if (low_cnt_r != rspm_pkg::RST_CNT_W'(rspm_pkg::MIN_RST_LOW_CYC)) begin
        low_cnt_r <= low_cnt_r + 1'b1;
      end
    end else begin
      low_cnt_r <= '0;
      if (low_cnt_r != '0) begin
        short_r <= low_cnt_r <
                   rspm_pkg::RST_CNT_W'(rspm_pkg::MIN_RST_LOW_CYC);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // spare pins: drive per config, live and sticky status
  for (genvar g = 0; g < rspm_pkg::PIN_CNT; g++) begin : g_spare
    always_ff @(posedge clk) begin
      if (int_rst || state_r == rspm_pkg::ST_RESET) begin
        spare_oe_r[g]  <= 1'b0;
        spare_out_r[g] <= 1'b0;
      end else begin
        spare_oe_r[g]  <= cfg_drives(cfg[g]);
        spare_out_r[g] <= cfg[g] == rspm_pkg::CFG_DRIVE_HIGH;
      end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
      if (int_rst || state_r == rspm_pkg::ST_RESET) begin
        live_r[g]  <= rspm_pkg::LIVE_RST[g];
        latch_r[g] <= rspm_pkg::LATCH_RST[g];
      end else begin
        live_r[g]  <= pad_in.spare[g];
        latch_r[g] <= (latch_r[g] && !status_clear[g]) ||
                      pad_in.spare[g];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // chip select: driven during autoconfig, input otherwise
  always_ff @(posedge clk) begin
    if (int_rst) begin
      sel_oe_r    <= 1'b0;
      sel_out_r   <= rspm_pkg::SEL_IDLE;
      slave_sel_r <= rspm_pkg::SEL_IDLE;
    end else begin
      sel_oe_r    <= state_r == rspm_pkg::ST_AUTOCFG;
      sel_out_r   <= (state_r == rspm_pkg::ST_AUTOCFG) ?
                     eep_select_low : rspm_pkg::SEL_IDLE;
      slave_sel_r <= (state_r == rspm_pkg::ST_RUN && spi_host) ?
                     pad_in.spi_select_low : rspm_pkg::SEL_IDLE;
    end
  end

  // data line: slave read data out, or eeprom data in
  always_ff @(posedge clk) begin
    if (int_rst) begin
      dout_oe_r  <= 1'b0;
      dout_out_r <= 1'b0;
      eep_data_r <= 1'b0;
    end else begin
      dout_oe_r  <= state_r == rspm_pkg::ST_RUN && spi_host &&
                    slave_read_active && !pad_in.spi_select_low;
      dout_out_r <= slave_read_active && slave_read_data;
      eep_data_r <= (state_r == rspm_pkg::ST_AUTOCFG) &&
                    pad_in.spi_data_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from a flop
  assign pad_oe  = '{spare: spare_oe_r, spi_select_low: sel_oe_r,
                     spi_data_out: dout_oe_r};
  assign pad_out = '{spare: spare_out_r, spi_select_low: sel_out_r,
                     spi_data_out: dout_out_r};
  assign pin_status_reg   = {latch_r, live_r};
  assign straps           = strap_r;
  assign reset_done       = done_r;
  assign autocfg_active   = autocfg_r;
  assign reset_too_short  = short_r;
  assign eep_read_data    = eep_data_r;
  assign slave_select_low = slave_sel_r;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  // internal reset in the antecedent: srst may fall at this very edge
  AST_FACTORY_SAMPLE: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RESET && !int_rst) |=>
      (straps.factory == $past(pad_in.spare[3]) && reset_done))
    else $error("factory strap not caught at reset release");

  AST_HOST_DECODE: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RESET && !int_rst) |=>
      (straps.host_mode == host_decode($past(pad_in.spi_data_out),
                                       $past(pad_in.spi_select_low))))
    else $error("host mode not decoded from straps");

  AST_INDEX_SAMPLE: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RESET && !int_rst) |=>
      straps.autoconfig_index == $past(pad_in.spare[2:0]))
    else $error("autoconfig index not caught");

  AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (srst)
    (reset_done && global_reset_low) |=> $stable(straps))
    else $error("straps changed without reset");

  AST_RESET_QUIET: assert property (@(posedge clk) disable iff (srst)
    !global_reset_low |=> (pad_oe == '0 && !reset_done &&
                           pin_status_reg == 8'h00))
    else $error("pads driven or state kept during reset");

  AST_SPARE_DRIVE: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RUN && global_reset_low &&
     pin_ctrl_reg_2[rspm_pkg::CFG3_LSB +: rspm_pkg::CFG_W] ==
       rspm_pkg::CFG_DRIVE_LOW) |=>
      (pad_oe.spare[3] && !pad_out.spare[3]))
    else $error("spare pin 3 not driven low as configured");

  AST_LIVE_STATUS: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RUN && global_reset_low) |=>
      pin_status_reg[3:0] == $past(pad_in.spare))
    else $error("live status does not follow pins");

  AST_STICKY: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RUN && global_reset_low &&
     (pad_in.spare[3] ||
      (pin_status_reg[7] && !status_clear[3]))) |=> pin_status_reg[7])
    else $error("sticky bit for pin 3 lost");

  AST_SEL_MASTER: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_AUTOCFG && global_reset_low) |=>
      (pad_oe.spi_select_low && autocfg_active != $past(eep_done)))
    else $error("chip select not driven during autoconfig");

  AST_SEL_RELEASE: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RUN) |=> !pad_oe.spi_select_low)
    else $error("chip select still driven in normal run");

  AST_DOUT_READ_ONLY: assert property (@(posedge clk) disable iff (srst)
    pad_oe.spi_data_out |-> ($past(slave_read_active) &&
                             !$past(pad_in.spi_select_low)))
    else $error("data out driven outside a read");

  AST_EEP_DATA: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_AUTOCFG && global_reset_low) |=>
      eep_read_data == $past(pad_in.spi_data_out))
    else $error("eeprom data not taken from data line");

  AST_SEL_FORWARD: assert property (@(posedge clk) disable iff (srst)
    (state_r == rspm_pkg::ST_RUN && global_reset_low && spi_host) |=>
      slave_select_low == $past(pad_in.spi_select_low))
    else $error("chip select not passed to slave engine");

endmodule : rspm_pin_mux

`default_nettype wire

// ### pkg/rspm_pkg.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// shared constants and types for the strap and shared pin mux
package rspm_pkg;

  // spare pin count and control field layout
  localparam int          PIN_CNT        = 4;
  localparam int          CFG_W          = 2;
  localparam int          CFG0_LSB       = 0;  // pin 0 in pin_ctrl_reg_1
  localparam int          CFG1_LSB       = 4;  // pin 1 in pin_ctrl_reg_1
  localparam int          CFG2_LSB       = 0;  // pin2_cfg_field in reg 2
  localparam int          CFG3_LSB       = 4;  // pin3_cfg_field in reg 2
  localparam int          STAT_LIVE_LSB  = 0;
  localparam int          STAT_LATCH_LSB = 4;

  // spare pin configuration codes
  localparam logic [1:0]  CFG_INPUT      = 2'h0;
  localparam logic [1:0]  CFG_INPUT_ALT  = 2'h1;
  localparam logic [1:0]  CFG_DRIVE_LOW  = 2'h2;
  localparam logic [1:0]  CFG_DRIVE_HIGH = 2'h3;

  // reset values
  localparam logic [3:0]  LIVE_RST       = 4'h0;
  localparam logic [3:0]  LATCH_RST      = 4'h0;
  localparam logic        SEL_IDLE       = 1'h1;

  // timing: least low time of the global reset pin
  localparam int          CLK_PERIOD_NS    = 50;
  localparam int          MIN_RST_LOW_NS   = 1000;
  localparam int          MIN_RST_LOW_CYC  =
    (MIN_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RST_CNT_W        = 5;

  // host interface mode decoded from the two interface straps
  typedef enum logic [1:0] {
    HOST_I2C_SLAVE  = 2'h0,
    HOST_SPI_SLAVE  = 2'h1,
    HOST_SPI_MASTER = 2'h2,
    HOST_RESERVED   = 2'h3
  } rspm_host_type;

  // sequence: reset -> (autoconfig) -> run
  typedef enum logic [1:0] {
    ST_RESET   = 2'h0,
    ST_AUTOCFG = 2'h1,
    ST_RUN     = 2'h3
  } rspm_state_type;

  // one bit per shared pad
  typedef struct packed {
    logic [3:0] spare;
    logic       spi_select_low;
    logic       spi_data_out;
  } rspm_pad_type;

  // values caught on the release of the global reset
  typedef struct packed {
    logic          factory;
    rspm_host_type host_mode;
    logic [2:0]    autoconfig_index;
  } rspm_strap_type;

  localparam rspm_strap_type STRAP_RST = '{factory: 1'h0,
                                           host_mode: HOST_I2C_SLAVE,
                                           autoconfig_index: 3'h0};

endpackage : rspm_pkg

`default_nettype wire

// ### verification/reset_strap_and_shared_pin_mux_test.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(name, exp, got) \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    $display("BAD %s exp %h got %h", name, exp, got); \
    num_errors++; \
  end

////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the strap and shared pin mux
module reset_strap_and_shared_pin_mux_test;
  logic                    clk = 1'b0;
  logic                    srst, global_reset_low, reset_done;
  rspm_pkg::rspm_pad_type  pad_in, pad_out, pad_oe;
  logic [7:0]              pin_ctrl_reg_1, pin_ctrl_reg_2, pin_status_reg;
  logic [3:0]              status_clear, spare_drv;
  rspm_pkg::rspm_strap_type straps, strap;
  logic                    autocfg_active, reset_too_short, eep_select_low;
  logic                    eep_done, eep_read_data, slave_read_active;
  logic                    slave_read_data, slave_select_low, strap_hold;
  logic                    host_sel_low, eep_bit;
  int                      num_errors = 0;
  int                      samples_checked = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  rspm_pin_mux dut (.clk, .srst, .global_reset_low, .pad_in, .pad_out,
    .pad_oe, .pin_ctrl_reg_1, .pin_ctrl_reg_2, .status_clear,
    .pin_status_reg, .straps, .reset_done, .autocfg_active, .reset_too_short,
    .eep_select_low, .eep_done, .eep_read_data, .slave_read_active,
    .slave_read_data, .slave_select_low);

  rspm_far_side far (.clk, .strap_hold, .strap, .spare_drv, .host_sel_low,
    .eep_bit, .pad_out, .pad_oe, .pad_in);

  ////////////////////////////////////////////////////////////////////////////
  // waits n rising edges, then looks at settled outputs
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // pulses the reset pin low with given straps on the pads
  task automatic restart(input rspm_pkg::rspm_strap_type s, input int low);
    @(posedge clk);
    global_reset_low <= 1'b0;
    strap            <= s;
    strap_hold       <= 1'b1;
    repeat (low) @(posedge clk);
    @(negedge clk);
    `CHK("oe in reset", 6'h00, pad_oe)
    `CHK("done in reset", 1'b0, reset_done)
    `CHK("straps in reset", 6'h00, straps)
    @(posedge clk);
    global_reset_low <= 1'b1;
    settle(1);
  endtask : restart

  // every config code on every spare pin, then live and sticky status
  task automatic spare_and_status;
    logic [1:0] k;
    logic [3:0] eoe, eout;
    logic [7:0] r1, r2;
    logic [3:0] drv_t [6] = '{4'h0, 4'h9, 4'h0, 4'h0, 4'h8, 4'h0};
    logic [3:0] clr_t [6] = '{4'hf, 4'h0, 4'h0, 4'h1, 4'h8, 4'h8};
    logic [7:0] exp_t [6] = '{8'h00, 8'h99, 8'h90, 8'h80, 8'h88, 8'h00};
    for (int c = 0; c < 4; c++) begin
      r1 = 8'hcc;
      r2 = 8'hcc;
      for (int i = 0; i < 4; i++) begin
        k = 2'(c + i);
        eoe[i] = k[1];
        eout[i] = (k == rspm_pkg::CFG_DRIVE_HIGH);
        if (i < 2) r1[4*i +: 2] = k;
        else r2[4*(i-2) +: 2] = k;
      end
      @(posedge clk);
      pin_ctrl_reg_1 <= r1;
      pin_ctrl_reg_2 <= r2;
      settle(2);
      `CHK("spare oe", eoe, pad_oe.spare)
      `CHK("spare out", eout, pad_out.spare & eoe)
    end
    for (int j = 0; j < 6; j++) begin
      @(posedge clk);
      pin_ctrl_reg_1 <= 8'h00;
      pin_ctrl_reg_2 <= 8'h00;
      spare_drv      <= drv_t[j];
      status_clear   <= clr_t[j];
      settle(2);
      `CHK("status", exp_t[j], pin_status_reg)
    end
    @(posedge clk);
    status_clear <= 4'h0;
  endtask : spare_and_status

  // eeprom select, read data and hand-back of chip select
  task automatic autocfg_run;
    `CHK("sel oe", 1'b1, pad_oe.spi_select_low)
    @(posedge clk);
    eep_select_low <= 1'b0;
    eep_bit        <= 1'b1;
    settle(3);
    `CHK("sel out", 1'b0, pad_out.spi_select_low)
    `CHK("eep data", 1'b1, eep_read_data)
    @(posedge clk);
    eep_bit <= 1'b0;
    settle(3);
    `CHK("eep data", 1'b0, eep_read_data)
    @(posedge clk);
    eep_select_low <= 1'b1;
    eep_done       <= 1'b1;
    settle(3);
    `CHK("autocfg end", 1'b0, autocfg_active)
    `CHK("sel released", 1'b0, pad_oe.spi_select_low)
    @(posedge clk);
    eep_done <= 1'b0;
  endtask : autocfg_run

  ////////////////////////////////////////////////////////////////////////////
  // watchdog on the whole run
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    final_report();
  end

  // main sequence: one reset per host mode
  initial begin
    rspm_pkg::rspm_strap_type s;
    srst = 1'b1;
    global_reset_low = 1'b1;
    pin_ctrl_reg_1 = 8'h00;
    pin_ctrl_reg_2 = 8'h00;
    status_clear = 4'h0;
    eep_select_low = 1'b1;
    eep_done = 1'b0;
    slave_read_active = 1'b0;
    slave_read_data = 1'b0;
    strap_hold = 1'b1;
    strap = '0;
    spare_drv = 4'h0;
    host_sel_low = 1'b1;
    eep_bit = 1'b0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      s = '{factory: m[0], host_mode: rspm_pkg::rspm_host_type'(m[1:0]),
            autoconfig_index: 3'(2 * m + 1)};
      restart(s, (m == 0) ? 4 : 24);
      `CHK("straps", s, straps)
      `CHK("reset done", 1'b1, reset_done)
      @(posedge clk);
      strap_hold   <= 1'b0;
      spare_drv    <= ~{s.factory, s.autoconfig_index};
      host_sel_low <= 1'b0;
      settle(2);
      `CHK("straps held", s, straps)
      `CHK("short reset", (m == 0), reset_too_short)
      `CHK("autocfg", (m == 2), autocfg_active)
      `CHK("slave sel", (m != 1), slave_select_low)
      @(posedge clk);
      slave_read_active <= 1'b1;
      slave_read_data   <= 1'b1;
      settle(2);
      `CHK("data oe", (m == 1), pad_oe.spi_data_out)
      if (m == 1) begin
        `CHK("data out", 1'b1, pad_out.spi_data_out)
      end
      @(posedge clk);
      slave_read_active <= 1'b0;
      settle(2);
      `CHK("data idle", 1'b0, pad_oe.spi_data_out)
      if (m == 0) spare_and_status();
      if (m == 2) autocfg_run();
    end
    final_report();
  end
endmodule : reset_strap_and_shared_pin_mux_test

`default_nettype wire

// ### verification/rspm_far_side.sv
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// board straps, external spi master select and eeprom data on shared pads
module rspm_far_side (
  input  wire logic                     clk,
  input  wire logic                     strap_hold,
  input  wire rspm_pkg::rspm_strap_type strap,
  input  wire logic [3:0]               spare_drv,
  input  wire logic                     host_sel_low,
  input  wire logic                     eep_bit,
  input  wire rspm_pkg::rspm_pad_type   pad_out,
  input  wire rspm_pkg::rspm_pad_type   pad_oe,
  output var  rspm_pkg::rspm_pad_type   pad_in
);
  logic                   toggle_r = 1'b0;
  rspm_pkg::rspm_pad_type far_drv;

  // a released data line shows a changing pattern, never the last value
  always @(posedge clk) begin
    toggle_r <= ~toggle_r;
  end

  // levels that board, host and eeprom put on each pad
  always_comb begin
    far_drv.spare = strap_hold ? {strap.factory, strap.autoconfig_index}
                               : spare_drv;
    far_drv.spi_select_low = strap_hold ? strap.host_mode[0]
                                        : host_sel_low;
    far_drv.spi_data_out = strap_hold ? strap.host_mode[1] : toggle_r;
    // eeprom answers only while the device selects it
    if (!strap_hold && pad_oe.spi_select_low && !pad_out.spi_select_low) begin
      far_drv.spi_data_out = eep_bit;
    end
  end

  // the device wins where its enable is high
  always_comb begin
    pad_in = rspm_pkg::rspm_pad_type'((pad_oe & pad_out) | (~pad_oe & far_drv));
  end
endmodule : rspm_far_side

`default_nettype wire
